// ---- pkg/ifsd_consts.svh ----
// Constants for the interrupt flag skip decoder
`ifndef IFSD_CONSTS_SVH
`define IFSD_CONSTS_SVH
`define IFSD_OP_SERIAL     10'h288
`define IFSD_OP_TIMER_ONE  10'h280
`define IFSD_OP_TIMER_TWO  10'h281
`define IFSD_OP_TIMER_THREE 10'h282
`define IFSD_EN_SERIAL_BIT  3
`define IFSD_EN_T1_BIT      2
`define IFSD_EN_T2_BIT      3
`define IFSD_EN_T3_BIT      0
`define IFSD_FLAG_RESET     4'h0
`define IFSD_CTRL_RESET     4'h0
`define IFSD_SKIP_CYCLES    1
`endif

// ---- pkg/ifsd_pkg.sv ----
// Types for the interrupt flag skip decoder
package ifsd_pkg;
  typedef enum logic [2:0] {
    IFSD_NONE                     = 3'h0,
    IFSD_SKIP_ON_SERIAL_FLAG      = 3'h1,
    IFSD_SKIP_ON_TIMER_ONE_FLAG   = 3'h2,
    IFSD_SKIP_ON_TIMER_TWO_FLAG   = 3'h3,
    IFSD_SKIP_ON_TIMER_THREE_FLAG = 3'h4
  } ifsd_op_t;
  typedef enum logic [1:0] {
    IFSD_RUN  = 2'b00,
    IFSD_SKIP = 2'b01
  } ifsd_state_t;
  // Flag order: 0 serial, 1 timer one, 2 timer two, 3 timer three
  typedef struct packed {
    logic [3:0] set;
  } ifsd_flag_set_t;
  typedef struct packed {
    logic       valid;
    logic       skip;
    logic [3:0] clear;
  } ifsd_result_t;
endpackage

// ---- verilog/ifsd_opcode_decode.sv ----
// Opcode match for the four flag skip instructions
`include "ifsd_consts.svh"
module ifsd_opcode_decode
  import ifsd_pkg::*;
(
  input  wire logic [9:0] instr,
  output ifsd_op_t        op
);
  function automatic ifsd_op_t ifsd_match(input logic [9:0] w);
    ifsd_op_t r;
    r = IFSD_NONE;
    if (w == `IFSD_OP_SERIAL) begin
      r = IFSD_SKIP_ON_SERIAL_FLAG;
    end else if (w == `IFSD_OP_TIMER_ONE) begin
      r = IFSD_SKIP_ON_TIMER_ONE_FLAG;
    end else if (w == `IFSD_OP_TIMER_TWO) begin
      r = IFSD_SKIP_ON_TIMER_TWO_FLAG;
    end else if (w == `IFSD_OP_TIMER_THREE) begin
      r = IFSD_SKIP_ON_TIMER_THREE_FLAG;
    end
    return r;
  endfunction

  assign op = ifsd_match(instr);
endmodule

// ---- verilog/ifsd_flag_bank.sv ----
// Four sticky interrupt request flags
`include "ifsd_consts.svh"
module ifsd_flag_bank
  import ifsd_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire ifsd_flag_set_t flag_set,
  input  wire logic [3:0]     flag_clear,
  output logic [3:0]          flags
);
  logic [3:0] next_flags;

  // Set wins over a clear in the same cycle so no request is lost
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_flag
      always_comb begin
        next_flags[i] = flag_set.set[i] | (flags[i] & ~flag_clear[i]);
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `IFSD_FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// ---- verilog/ifsd_skip_decoder.sv ----
// Flag skip instruction decoder and executor
`include "ifsd_consts.svh"
module ifsd_skip_decoder
  import ifsd_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           instr_valid,
  input  wire logic [9:0]     instr,
  input  wire logic [3:0]     irq_control_reg_one,
  input  wire logic [3:0]     irq_control_reg_two,
  input  wire ifsd_flag_set_t flag_set,
  input  wire logic           carry_in,
  output logic                skip_next,
  output logic                executed,
  output logic                carry_flag,
  output logic                serial_request_flag,
  output logic                timer_one_request_flag,
  output logic                timer_two_request_flag,
  output logic                timer_three_request_flag
);
  ifsd_op_t     op;
  logic [3:0]   flags;
  logic [3:0]   enables;
  ifsd_result_t res;
  logic [3:0]   clear_q;
  logic [3:0]   next_clear;
  logic         next_skip_next;
  logic         next_executed;
  logic         next_carry;
  logic [3:0]   next_req;
  logic [3:0]   req_q;

  ifsd_opcode_decode u_dec (
    .instr (instr),
    .op    (op)
  );

  ifsd_flag_bank u_flags (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .flag_set   (flag_set),
    .flag_clear (next_clear),
    .flags      (flags)
  );

  assign enables = {irq_control_reg_two[`IFSD_EN_T3_BIT],
                    irq_control_reg_one[`IFSD_EN_T2_BIT],
                    irq_control_reg_one[`IFSD_EN_T1_BIT],
                    irq_control_reg_two[`IFSD_EN_SERIAL_BIT]};

  // Pick which flag the instruction tests; none when not a match
  function automatic logic [3:0] ifsd_select(input ifsd_op_t o);
    logic [3:0] s;
    s = 4'h0;
    case (o)
      IFSD_SKIP_ON_SERIAL_FLAG:      s = 4'h1;
      IFSD_SKIP_ON_TIMER_ONE_FLAG:   s = 4'h2;
      IFSD_SKIP_ON_TIMER_TWO_FLAG:   s = 4'h4;
      IFSD_SKIP_ON_TIMER_THREE_FLAG: s = 4'h8;
      default:                       s = 4'h0;
    endcase
    return s;
  endfunction

  always_comb begin
    logic [3:0] sel;
    logic [3:0] hit;
    sel = ifsd_select(op) & {4{instr_valid}};
    hit = sel & ~enables & flags;
    res.valid = |sel;
    // flag zero lets the next instruction run
    res.skip  = |hit;
    res.clear = hit;
    next_clear     = res.clear;
    next_skip_next = res.skip;
    next_executed  = res.valid;
    // carry is never touched by these instructions
    next_carry     = carry_in;
    // Set wins over clear here too, so the ports track the flag bank
    next_req       = flag_set.set | (flags & ~res.clear);
  end

  // Single-cycle execution: result is registered at the next edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      skip_next  <= 1'b0;
      executed   <= 1'b0;
      carry_flag <= 1'b0;
      clear_q    <= 4'h0;
      req_q      <= `IFSD_FLAG_RESET;
    end else begin
      skip_next  <= next_skip_next;
      executed   <= next_executed;
      carry_flag <= next_carry;
      clear_q    <= next_clear;
      req_q      <= next_req;
    end
  end

  assign serial_request_flag      = req_q[0];
  assign timer_one_request_flag   = req_q[1];
  assign timer_two_request_flag   = req_q[2];
  assign timer_three_request_flag = req_q[3];
endmodule

// ---- test/ifsd_skip_decoder_asserts.sv ----
// Concurrent checks on the skip decoder ports
module ifsd_skip_decoder_chk
  import ifsd_pkg::*;
(
  input wire logic           mclk, rst_n, instr_valid, carry_in,
  input wire logic [9:0]     instr,
  input wire logic [3:0]     irq_control_reg_one, irq_control_reg_two,
  input wire ifsd_flag_set_t flag_set,
  input wire logic           skip_next, executed, carry_flag,
  input wire logic           serial_request_flag, timer_one_request_flag,
  input wire logic           timer_two_request_flag, timer_three_request_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire [3:0] f = {timer_three_request_flag, timer_two_request_flag,
                  timer_one_request_flag, serial_request_flag};
  wire [3:0] e = {irq_control_reg_two[0], irq_control_reg_one[3:2],
                  irq_control_reg_two[3]};
  wire [3:0] h = {instr == 10'h282, instr == 10'h281, instr == 10'h280,
                  instr == 10'h288} & {4{instr_valid}};
  wire [3:0] t = h & ~e & f;
  // A set pulse wins over a clear, so quiet cycles only
  wire       q = flag_set.set == 4'h0;
  AST_SER: assert property (t[0] && q |=> skip_next && !f[0])
    else $error("serial skip wrong");
  AST_T1: assert property (t[1] && q |=> skip_next && !f[1])
    else $error("timer one skip wrong");
  AST_T2: assert property (t[2] && q |=> skip_next && !f[2])
    else $error("timer two skip wrong");
  AST_T3: assert property (t[3] && q |=> skip_next && !f[3])
    else $error("timer three skip wrong");
  AST_NOP: assert property (|(h & e) && q |=> !skip_next && $stable(f))
    else $error("enabled skip not a no-operation");
  AST_ZERO: assert property (|(h & ~e & ~f) |=> executed && !skip_next)
    else $error("clear flag still skipped");
  AST_CARRY: assert property ($past(rst_n) |-> carry_flag == $past(carry_in))
    else $error("carry altered");
  AST_IDLE: assert property (h == 4'h0 |=> !executed && !skip_next)
    else $error("unknown word executed");
  cover property (t[0]);
  cover property (|(h & e));
  cover property (|(h & ~e & ~f));
endmodule
bind ifsd_skip_decoder ifsd_skip_decoder_chk chk_u (.*);

// ---- test/test_interrupt_flag_skip_decoder.sv ----
// Directed bench for the skip decoder
module test_interrupt_flag_skip_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import ifsd_pkg::*;
  logic           mclk = 0, rst_n = 0, instr_valid = 0, carry_in = 0;
  logic [9:0]     instr = 10'h000;
  logic [3:0]     r1 = 4'h0, r2 = 4'h0, fl;
  ifsd_flag_set_t fs = '0;
  logic           sk, ex, cy;
  int             fails = 0, checks_done = 0, cyc = 0;
  logic [9:0]     w [4] = '{10'h288, 10'h280, 10'h281, 10'h282};
  // Own enable low, all other enables high
  logic [3:0]     d1 [4] = '{4'hc, 4'h8, 4'h4, 4'hc};
  logic [3:0]     d2 [4] = '{4'h1, 4'h9, 4'h9, 4'h8};
  ifsd_skip_decoder dut_u (.mclk, .rst_n, .instr_valid, .instr,
    .irq_control_reg_one(r1), .irq_control_reg_two(r2), .flag_set(fs),
    .carry_in, .skip_next(sk), .executed(ex), .carry_flag(cy),
    .serial_request_flag(fl[0]), .timer_one_request_flag(fl[1]),
    .timer_two_request_flag(fl[2]), .timer_three_request_flag(fl[3]));
  initial forever #20 mclk = ~mclk;
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [6:0] exp, logic [6:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic setf(logic [3:0] m);
    @(posedge mclk);
    #1 fs.set = m;
    @(posedge mclk);
    #1 fs.set = 4'h0;
  endtask
  // Carry toggles each call so a stuck carry path shows
  task automatic run(logic [9:0] c, logic [3:0] a, b, logic [5:0] exp);
    @(posedge mclk);
    #1 {instr_valid, instr, r1, r2} = {1'b1, c, a, b};
    carry_in = ~carry_in;
    @(posedge mclk);
    #1 instr_valid = 0;
    cmp("carry skip executed flags", {carry_in, exp}, {cy, sk, ex, fl});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 300) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst_n = 1;
    foreach (w[i]) begin
      setf(4'hf);
      run(w[i], 4'hc, 4'h9, {2'b01, 4'hf});
      run(w[i], d1[i], d2[i], {2'b11, ~(4'h1 << i)});
      run(w[i], d1[i], d2[i], {2'b01, ~(4'h1 << i)});
    end
    setf(4'hf);
    @(posedge mclk);
    #1 {instr_valid, instr, r1, r2, fs.set} = {1'b1, 10'h288, 8'hc1, 4'h1};
    carry_in = ~carry_in;
    @(posedge mclk);
    #1 {instr_valid, fs.set} = 5'h00;
    cmp("set beats clear", {carry_in, 6'h3f}, {cy, sk, ex, fl});
    run(10'h283, 4'h0, 4'h0, {2'b00, 4'hf});
    run(10'h088, 4'h0, 4'h0, {2'b00, 4'hf});
    final_report();
  end
endmodule
